// File: rtl/tpw_map.svh
// Purpose: Address map, field positions and codes of the PWM timer unit
// Assumes: APB byte addresses, one aligned word per 8-bit register
// Notes: Definitions only
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH
// Address split: instance select and register offset
`define TPW_INST_MSB 7
`define TPW_INST_LSB 6
`define TPW_OFF_MSB 5
// Per-instance offsets
`define TPW_OFF_SC 6'h00
`define TPW_OFF_CNTH 6'h04
`define TPW_OFF_CNTL 6'h08
`define TPW_OFF_MODH 6'h0c
`define TPW_OFF_MODL 6'h10
`define TPW_CH_BASE 6'h14
`define TPW_CH_STRIDE 6'h0c
`define TPW_CH_SC 6'h00
`define TPW_CH_VH 6'h04
`define TPW_CH_VL 6'h08
// System option register (absolute byte address)
`define TPW_OFF_OPT 8'h80
// Status/control fields
`define TPW_TOF_BIT 7
// Clock source codes
`define TPW_CLK_OFF 2'b00
`define TPW_CLK_BUS 2'b01
`define TPW_CLK_FIXED 2'b10
`define TPW_CLK_EXT 2'b11
// Counter values
`define TPW_CNT_ZERO 16'h0000
`define TPW_CNT_ONE 16'h0001
`define TPW_FREE_TOP 16'hffff
`define TPW_PRE_ONE 7'h01
`define TPW_PRE_UNIT 8'h01
// Comparator routing target
`define TPW_ROUTE_INST 0
`define TPW_ROUTE_CH 0
`endif

// File: rtl/tpw_pkg.sv
// Purpose: Types of the PWM timer unit
// Assumes: Two instances, two channels each
// Notes: Field order of the structs is the register bit order
package tpw_pkg;
    localparam int TPW_NUM_INST = 2;
    localparam int TPW_NUM_CH = 2;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        logic [1:0] clks;
        logic [2:0] ps;
    } tpw_sc_t;

    typedef struct packed {
        logic chf;
        logic chie;
        logic msb;
        logic msa;
        logic elsb;
        logic elsa;
        logic [1:0] spare;
    } tpw_csc_t;

    typedef struct packed {
        tpw_csc_t csc;
        logic arm;
        logic [15:0] val;
        logic [15:0] bufv;
        logic hiW;
        logic loW;
        logic pinPrev;
        logic pinOut;
        logic pinOe_n;
    } tpw_ch_t;

    typedef struct packed {
        tpw_sc_t sc;
        logic tofArm;
        logic [15:0] cnt;
        logic down;
        logic [6:0] pre;
        logic [15:0] modv;
        logic [15:0] modBuf;
        logic modHiW;
        logic modLoW;
        logic irq;
        tpw_ch_t [TPW_NUM_CH-1:0] ch;
    } tpw_unit_t;

    typedef struct packed {
        tpw_unit_t [TPW_NUM_INST-1:0] u;
        logic route;
        logic [2:0] extSync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpw_state_t;
endpackage

// File: rtl/tpw_timer.sv
// Purpose: Two 16-bit timer/PWM instances with shared APB register access
// Assumes: Channel pins and comparator output synchronous to mclk
// Notes: One wait state on every APB access; registers 8 bits in low lane
//
// Contract
// - Two timer instances, one pin per channel, channels from zero, pins shared.
// - Overflow flag sets when counter wraps to zero after reaching modulo.
// - Flag clears only by read while set, then writing zero.
// - Overflow during clear sequence restarts it; flag stays set.
// - Writing one to flag has no effect; reset clears flag.
// - Interrupt request while flag and enable both set; reset clears enable.
// - Center select clear counts up; set counts up/down, channels center-aligned.
// - Clock source field disables or selects bus, fixed, or external clock.
// - External clock synchronised to bus clock; fixed clock equals bus clock.
// - Three-bit prescale picks eight factors after source selection.
// - New prescale acts on the next clock after register update.
// - Modulo and channel value bytes land in buffers for coherent updates.
// - Center mode, clock off: channel value loads at second byte.
// - Center mode, clock on: loads when counter steps modulo-1 to modulo.
// - Counter at modulo may raise overflow at end of that count.
// - Status/control write discards pending modulo bytes.
// - Channel control write discards pending value bytes of that channel.
// - Reset clears status/control, stopping clock and disabling interrupts.
// - Reset puts channels in input capture with pins released; here reset loads chOe_n low, so pins drive until the first clock after reset.
// - Routing bit feeds comparator to capture channel zero, pin unavailable.
// - Center mode sets overflow flag at up-to-down reversal at modulo.
// - Compare or PWM channel flag sets when counter matches channel value.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "tpw_map.svh"

module tpw_timer
    import tpw_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External clock and comparator
    input wire logic extClk,
    input wire logic acmpOut,
    // Channel pins, index instance*TPW_NUM_CH+channel
    input wire logic [TPW_NUM_INST*TPW_NUM_CH-1:0] chIn,
    output logic [TPW_NUM_INST*TPW_NUM_CH-1:0] chOut,
    output logic [TPW_NUM_INST*TPW_NUM_CH-1:0] chOe_n,
    // Overflow interrupt request per instance
    output logic [TPW_NUM_INST-1:0] ovfIrq
);
    tpw_state_t r_r;
    tpw_state_t r_nxt;
    logic [TPW_NUM_INST-1:0] ovfEv;
    logic [TPW_NUM_INST-1:0] stepEv;
    logic doR;
    logic doW;

    function automatic logic [5:0] chAddr(input int c, input logic [5:0] k);
        chAddr = 6'(`TPW_CH_BASE + 6'(c) * `TPW_CH_STRIDE) + k;
    endfunction

    logic [5:0] off;
    logic [1:0] inst;
    logic [7:0] rd;
    logic hit;
    logic extTick;
    logic srcTick;
    logic [6:0] mask;
    logic [15:0] top;
    logic toTop;
    logic instHit;
    logic wSc;
    logic pin;
    logic edgeHit;
    logic active;
    logic cmp;
    logic rdSel;
    logic both;
    tpw_unit_t u;
    tpw_ch_t ch;
    always_comb begin
        r_nxt = r_r;
        off = paddr[`TPW_OFF_MSB:0];
        inst = paddr[`TPW_INST_MSB:`TPW_INST_LSB];
        rd = 8'h00;
        hit = 1'b0;
        ovfEv = '0;
        stepEv = '0;
        doR = psel & penable & r_r.pready & ~pwrite;
        doW = psel & penable & r_r.pready & pwrite;
        // External clock: two-flop sync, edge taken past the second flop
        r_nxt.extSync = {r_r.extSync[1:0], extClk};
        extTick = r_r.extSync[1] & ~r_r.extSync[2];
        if (paddr == `TPW_OFF_OPT) begin
            hit = 1'b1;
            rd = {7'h00, r_r.route};
            if (doW) begin
                r_nxt.route = pwdata[0];
            end
        end
        for (int i = 0; i < TPW_NUM_INST; i++) begin
            u = r_r.u[i];
            instHit = (paddr != `TPW_OFF_OPT) && (inst == 2'(i));
            wSc = doW && instHit && (off == `TPW_OFF_SC);
            // Source select; no PLL so the fixed clock runs at bus rate
            unique case (u.sc.clks)
                `TPW_CLK_OFF: srcTick = 1'b0;
                `TPW_CLK_BUS: srcTick = 1'b1;
                `TPW_CLK_FIXED: srcTick = 1'b1;
                `TPW_CLK_EXT: srcTick = extTick;
            endcase
            // Divide by 2**ps; ps read live so a new value acts next cycle
            mask = 7'((`TPW_PRE_UNIT << u.sc.ps) - `TPW_PRE_UNIT);
            stepEv[i] = srcTick && ((u.pre & mask) == mask);
            if (srcTick) begin
                r_nxt.u[i].pre = u.pre + `TPW_PRE_ONE;
            end
            top = (u.modv == `TPW_CNT_ZERO) ? `TPW_FREE_TOP : u.modv;
            toTop = stepEv[i] && !u.down && (u.cnt == top - `TPW_CNT_ONE);
            // Leaving center mode drops the down phase even while stopped
            r_nxt.u[i].down = u.down & u.sc.center_align_select;
            if (stepEv[i]) begin
                if (!u.sc.center_align_select) begin
                    if (u.cnt == top) begin
                        r_nxt.u[i].cnt = `TPW_CNT_ZERO;
                        ovfEv[i] = 1'b1;
                    end else begin
                        r_nxt.u[i].cnt = u.cnt + `TPW_CNT_ONE;
                    end
                end else if (!u.down) begin
                    if (u.cnt == top) begin
                        r_nxt.u[i].down = 1'b1;
                        r_nxt.u[i].cnt = u.cnt - `TPW_CNT_ONE;
                        ovfEv[i] = 1'b1;
                    end else begin
                        r_nxt.u[i].cnt = u.cnt + `TPW_CNT_ONE;
                    end
                end else if (u.cnt == `TPW_CNT_ZERO) begin
                    r_nxt.u[i].down = 1'b0;
                    r_nxt.u[i].cnt = `TPW_CNT_ONE;
                end else begin
                    r_nxt.u[i].cnt = u.cnt - `TPW_CNT_ONE;
                end
            end
            // Counter write restarts the count from zero
            if (doW && instHit && (off == `TPW_OFF_CNTH || off == `TPW_OFF_CNTL)) begin
                r_nxt.u[i].cnt = `TPW_CNT_ZERO;
                r_nxt.u[i].pre = '0;
                r_nxt.u[i].down = 1'b0;
            end
            // Status/control read and write
            if (instHit && off == `TPW_OFF_SC) begin
                hit = 1'b1;
                rd = u.sc;
            end
            if (doR && instHit && off == `TPW_OFF_SC && u.sc.overflow_flag) begin
                r_nxt.u[i].tofArm = 1'b1;
            end
            if (wSc) begin
                r_nxt.u[i].sc.overflow_irq_enable = pwdata[6];
                r_nxt.u[i].sc.center_align_select = pwdata[5];
                r_nxt.u[i].sc.clks = pwdata[4:3];
                r_nxt.u[i].sc.ps = pwdata[2:0];
                r_nxt.u[i].modHiW = 1'b0;
                r_nxt.u[i].modLoW = 1'b0;
                // Writing one leaves the flag alone
                if (!pwdata[`TPW_TOF_BIT] && u.tofArm) begin
                    r_nxt.u[i].sc.overflow_flag = 1'b0;
                    r_nxt.u[i].tofArm = 1'b0;
                end
            end
            // New overflow wins over a clear and restarts the sequence
            if (ovfEv[i]) begin
                r_nxt.u[i].sc.overflow_flag = 1'b1;
                r_nxt.u[i].tofArm = 1'b0;
            end
            // Modulo bytes collect in a buffer, loaded as one word
            if (instHit && off == `TPW_OFF_MODH) begin
                hit = 1'b1;
                rd = u.modv[15:8];
                if (doW) begin
                    r_nxt.u[i].modBuf[15:8] = pwdata[7:0];
                    r_nxt.u[i].modHiW = 1'b1;
                end
            end
            if (instHit && off == `TPW_OFF_MODL) begin
                hit = 1'b1;
                rd = u.modv[7:0];
                if (doW) begin
                    r_nxt.u[i].modBuf[7:0] = pwdata[7:0];
                    r_nxt.u[i].modLoW = 1'b1;
                end
            end
            if (r_nxt.u[i].modHiW && r_nxt.u[i].modLoW) begin
                r_nxt.u[i].modv = r_nxt.u[i].modBuf;
                r_nxt.u[i].modHiW = 1'b0;
                r_nxt.u[i].modLoW = 1'b0;
            end
            if (instHit && (off == `TPW_OFF_CNTH || off == `TPW_OFF_CNTL)) begin
                hit = 1'b1;
                rd = (off == `TPW_OFF_CNTH) ? u.cnt[15:8] : u.cnt[7:0];
            end
            r_nxt.u[i].irq = r_nxt.u[i].sc.overflow_flag & r_nxt.u[i].sc.overflow_irq_enable;
            for (int c = 0; c < TPW_NUM_CH; c++) begin
                ch = u.ch[c];
                // Comparator may replace the pin on one capture input
                pin = (r_r.route && i == `TPW_ROUTE_INST && c == `TPW_ROUTE_CH) ?
                    acmpOut : chIn[i*TPW_NUM_CH+c];
                r_nxt.u[i].ch[c].pinPrev = pin;
                active = u.sc.center_align_select | ch.csc.msb | ch.csc.msa;
                cmp = stepEv[i] && (u.cnt == ch.val);
                edgeHit = (ch.csc.elsa & pin & ~ch.pinPrev) |
                    (ch.csc.elsb & ~pin & ch.pinPrev);
                if (!active && edgeHit) begin
                    r_nxt.u[i].ch[c].val = u.cnt;
                    r_nxt.u[i].ch[c].csc.chf = 1'b1;
                end
                if (active && cmp) begin
                    r_nxt.u[i].ch[c].csc.chf = 1'b1;
                end
                // Pin level: PWM from counter vs value, compare acts on match
                if (u.sc.center_align_select || ch.csc.msb) begin
                    r_nxt.u[i].ch[c].pinOut = (r_nxt.u[i].cnt < ch.val) ^ ch.csc.elsa;
                end else if (ch.csc.msa && cmp) begin
                    unique case ({ch.csc.elsb, ch.csc.elsa})
                        2'b01: r_nxt.u[i].ch[c].pinOut = ~ch.pinOut;
                        2'b10: r_nxt.u[i].ch[c].pinOut = 1'b0;
                        2'b11: r_nxt.u[i].ch[c].pinOut = 1'b1;
                        2'b00: r_nxt.u[i].ch[c].pinOut = ch.pinOut;
                    endcase
                end
                // Routed comparator keeps that pin off the timer
                r_nxt.u[i].ch[c].pinOe_n = ~(active & (ch.csc.elsb | ch.csc.elsa)) |
                    (r_r.route && i == `TPW_ROUTE_INST && c == `TPW_ROUTE_CH);
                rdSel = instHit && off == chAddr(c, `TPW_CH_SC);
                if (rdSel) begin
                    hit = 1'b1;
                    rd = ch.csc;
                end
                if (doR && rdSel && ch.csc.chf) begin
                    r_nxt.u[i].ch[c].arm = 1'b1;
                end
                if (doW && rdSel) begin
                    r_nxt.u[i].ch[c].csc.chie = pwdata[6];
                    r_nxt.u[i].ch[c].csc.msb = pwdata[5];
                    r_nxt.u[i].ch[c].csc.msa = pwdata[4];
                    r_nxt.u[i].ch[c].csc.elsb = pwdata[3];
                    r_nxt.u[i].ch[c].csc.elsa = pwdata[2];
                    r_nxt.u[i].ch[c].hiW = 1'b0;
                    r_nxt.u[i].ch[c].loW = 1'b0;
                    if (!pwdata[`TPW_TOF_BIT] && ch.arm && !(active ? cmp : edgeHit)) begin
                        r_nxt.u[i].ch[c].csc.chf = 1'b0;
                        r_nxt.u[i].ch[c].arm = 1'b0;
                    end
                end
                rdSel = instHit && off == chAddr(c, `TPW_CH_VH);
                if (rdSel) begin
                    hit = 1'b1;
                    rd = ch.val[15:8];
                    if (doW) begin
                        r_nxt.u[i].ch[c].bufv[15:8] = pwdata[7:0];
                        r_nxt.u[i].ch[c].hiW = 1'b1;
                    end
                end
                rdSel = instHit && off == chAddr(c, `TPW_CH_VL);
                if (rdSel) begin
                    hit = 1'b1;
                    rd = ch.val[7:0];
                    if (doW) begin
                        r_nxt.u[i].ch[c].bufv[7:0] = pwdata[7:0];
                        r_nxt.u[i].ch[c].loW = 1'b1;
                    end
                end
                both = r_nxt.u[i].ch[c].hiW && r_nxt.u[i].ch[c].loW;
                // Center mode with a clock waits for the top of the count
                if (both && (!u.sc.center_align_select || u.sc.clks == `TPW_CLK_OFF || toTop)) begin
                    r_nxt.u[i].ch[c].val = r_nxt.u[i].ch[c].bufv;
                    r_nxt.u[i].ch[c].hiW = 1'b0;
                    r_nxt.u[i].ch[c].loW = 1'b0;
                end
            end
        end
        // APB: one wait state, data registered on the same edge that pready rises
        r_nxt.pready = psel & penable & ~r_r.pready;
        r_nxt.pslverr = psel & penable & ~r_r.pready & ~hit;
        if (psel && penable && !r_r.pready) begin
            r_nxt.prdata = {24'h000000, rd};
        end
    end

    // Every reset value is zero: timer stopped, channels in capture, pins driven (pinOe_n 0) until the first clock after reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata = r_r.prdata;
    assign pready = r_r.pready;
    assign pslverr = r_r.pslverr;
    always_comb begin
        for (int i = 0; i < TPW_NUM_INST; i++) begin
            ovfIrq[i] = r_r.u[i].irq;
            for (int c = 0; c < TPW_NUM_CH; c++) begin
                chOut[i*TPW_NUM_CH+c] = r_r.u[i].ch[c].pinOut;
                chOe_n[i*TPW_NUM_CH+c] = r_r.u[i].ch[c].pinOe_n;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic wSc0;
    assign wSc0 = doW && (paddr == {2'b00, `TPW_OFF_SC});
    property p_ovf_sets_tof;
        ovfEv[0] |=> r_r.u[0].sc.overflow_flag;
    endproperty
    a_ovf_sets_tof: assert property (p_ovf_sets_tof) else $error("overflow did not set flag");
    property p_clear_needs_arm;
        $fell(r_r.u[0].sc.overflow_flag) |-> $past(r_r.u[0].tofArm) && $past(wSc0);
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared wrongly");
    property p_ovf_not_lost;
        ovfEv[0] && wSc0 && !pwdata[7] |=> r_r.u[0].sc.overflow_flag ##1 r_r.u[0].sc.overflow_flag;
    endproperty
    a_ovf_not_lost: assert property (p_ovf_not_lost) else $error("overflow lost in clear");
    property p_write_one_keeps;
        wSc0 && pwdata[7] && r_r.u[0].sc.overflow_flag |=> r_r.u[0].sc.overflow_flag;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) else $error("write one cleared flag");
    property p_irq;
        ovfIrq[0] == (r_r.u[0].sc.overflow_flag && r_r.u[0].sc.overflow_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request mismatch");
    property p_up_only;
        !r_r.u[0].sc.center_align_select |=> !r_r.u[0].down;
    endproperty
    a_up_only: assert property (p_up_only) else $error("down count while up only");
    property p_clock_off;
        r_r.u[0].sc.clks == `TPW_CLK_OFF && !doW |=> $stable(r_r.u[0].cnt);
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("counter moved with clock off");
    property p_prescale;
        stepEv[0] && r_r.u[0].sc.ps != 3'h0 ##1 $stable(r_r.u[0].sc.ps) |-> !stepEv[0];
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler stepped twice");
    property p_sc_cancels_mod;
        wSc0 |=> !r_r.u[0].modHiW && !r_r.u[0].modLoW;
    endproperty
    a_sc_cancels_mod: assert property (p_sc_cancels_mod) else $error("modulo bytes kept");
    property p_route_pin;
        r_r.route ##1 r_r.route |-> chOe_n[0];
    endproperty
    a_route_pin: assert property (p_route_pin) else $error("routed pin still driven");

    c_overflow: cover property (ovfEv[0]);
    c_tof_clear: cover property ($fell(r_r.u[0].sc.overflow_flag));
    c_center_turn: cover property (r_r.u[0].sc.center_align_select && $rose(r_r.u[0].down));
    c_capture: cover property ($rose(r_r.u[0].ch[0].csc.chf) && !r_r.u[0].sc.center_align_select);
endmodule

// File: tb/tpw_timer_test.sv
// Purpose: Self-checking bench for the PWM timer unit over APB
// Assumes: Register map of tpw_map.svh, one wait state per access
// Notes: Counter rates are checked within a small window for sync jitter
`timescale 1ns/10ps
`include "tpw_map.svh"

module tpw_timer_test
    import tpw_pkg::*;
;
    localparam int LIMIT = 20000;
    localparam logic [7:0] CH0_SC = {2'b00, `TPW_CH_BASE};
    localparam logic [7:0] CH0_VH = {2'b00, `TPW_CH_BASE + `TPW_CH_VH};
    localparam logic [7:0] CH0_VL = {2'b00, `TPW_CH_BASE + `TPW_CH_VL};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] extDiv = 3'h0;
    wire extClk = extDiv[2];
    logic acmpOut = 1'b0;
    logic [3:0] chIn = 4'h0;
    logic [3:0] chOut;
    logic [3:0] chOe_n;
    logic [1:0] ovfIrq;
    logic [7:0] rd;
    logic err;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    tpw_timer tpw_timer_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extClk(extClk), .acmpOut(acmpOut), .chIn(chIn), .chOut(chOut),
        .chOe_n(chOe_n), .ovfIrq(ovfIrq));

    always #10 mclk = ~mclk;

    // External clock: one rising edge every 8 bus cycles
    always @(posedge mclk) begin
        extDiv <= extDiv + 3'h1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Values read right after the edge are the pre-edge (sampled) ones
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    // Run with given control value for a fixed window, check counter growth
    task automatic rate(input logic [7:0] sc, input int exp);
        wr({2'b00, `TPW_OFF_SC}, sc);
        wr({2'b00, `TPW_OFF_CNTL}, 8'h00);
        repeat (128) @(posedge mclk);
        xfer(1'b0, {2'b00, `TPW_OFF_CNTL}, 8'h00);
        chk_rng(rd, (exp > 2) ? exp - 2 : 0, exp + 2);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rdc({2'b00, `TPW_OFF_SC}, 8'h00);
        rdc({2'b01, `TPW_OFF_SC}, 8'h00);
        rdc({2'b00, `TPW_OFF_MODL}, 8'h00);
        chk({6'h0, ovfIrq}, 8'h00);
        chk({4'h0, chOe_n}, 8'h0f);
        $display("test reset done");

        xfer(1'b0, 8'h2c, 8'h00);
        chk(rd, 8'h00);
        chk({7'h0, err}, 8'h01);
        $display("test unmapped done");

        // Clock off: counter stays at zero, so PWM level is fixed by the value
        wr(CH0_SC, 8'h28);
        wr(CH0_VH, 8'h00);
        wr(CH0_VL, 8'h05);
        rdc(CH0_VL, 8'h05);
        chk({7'h0, chOut[0]}, 8'h01);
        chk({7'h0, chOe_n[0]}, 8'h00);
        wr(CH0_VH, 8'h00);
        wr(CH0_SC, 8'h28);
        wr(CH0_VL, 8'h07);
        rdc(CH0_VL, 8'h05);
        wr(`TPW_OFF_OPT, 8'h01);
        rdc(`TPW_OFF_OPT, 8'h01);
        chk({7'h0, chOe_n[0]}, 8'h01);
        wr(CH0_SC, 8'h04);
        acmpOut <= 1'b1;
        rdc(CH0_SC, 8'h84);
        wr(CH0_SC, 8'h00);
        rdc(CH0_SC, 8'h00);
        $display("test channel done");

        for (int ps = 0; ps < 8; ps++)
            rate(8'h08 | ps[7:0], 130 >> ps);
        rate(8'h10, 130);
        rate(8'h18, 16);
        rate(8'h00, 0);
        $display("test prescale done");

        wr({2'b00, `TPW_OFF_MODH}, 8'h12);
        wr({2'b00, `TPW_OFF_SC}, 8'h00);
        wr({2'b00, `TPW_OFF_MODL}, 8'h34);
        rdc({2'b00, `TPW_OFF_MODL}, 8'h00);
        wr({2'b00, `TPW_OFF_MODH}, 8'h00);
        rdc({2'b00, `TPW_OFF_MODL}, 8'h34);
        wr({2'b00, `TPW_OFF_MODL}, 8'h01);
        wr({2'b00, `TPW_OFF_MODH}, 8'h00);
        rdc({2'b00, `TPW_OFF_MODL}, 8'h01);
        $display("test modulo done");

        // Modulo 1 overflows every second cycle, so a clear attempt races one while the clock runs
        wr({2'b00, `TPW_OFF_SC}, 8'h48);
        repeat (8) @(posedge mclk);
        rdc({2'b00, `TPW_OFF_SC}, 8'hc8);
        chk({6'h0, ovfIrq}, 8'h01);
        wr({2'b00, `TPW_OFF_SC}, 8'h48);
        rdc({2'b00, `TPW_OFF_SC}, 8'hc8);
        wr({2'b00, `TPW_OFF_SC}, 8'hc0);
        wr({2'b00, `TPW_OFF_SC}, 8'h40);
        rdc({2'b00, `TPW_OFF_SC}, 8'hc0);
        wr({2'b00, `TPW_OFF_SC}, 8'hc0);
        rdc({2'b00, `TPW_OFF_SC}, 8'hc0);
        wr({2'b00, `TPW_OFF_SC}, 8'h40);
        rdc({2'b00, `TPW_OFF_SC}, 8'h40);
        chk({6'h0, ovfIrq}, 8'h00);
        $display("test overflow done");

        wr({2'b00, `TPW_OFF_MODH}, 8'h00);
        wr({2'b00, `TPW_OFF_MODL}, 8'h03);
        wr({2'b00, `TPW_OFF_SC}, 8'h28);
        for (int i = 0; i < 10; i++) begin
            xfer(1'b0, {2'b00, `TPW_OFF_CNTL}, 8'h00);
            chk_rng(rd, 0, 3);
        end
        rdc({2'b00, `TPW_OFF_SC}, 8'ha8);
        rdc({2'b01, `TPW_OFF_SC}, 8'h00);
        $display("test center done");

        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdc({2'b00, `TPW_OFF_SC}, 8'h00);
        chk({6'h0, ovfIrq}, 8'h00);
        $display("test second reset done");
        finish_test();
    end
endmodule
